//--- pm_defines.svh
// Named constants for the battery monitor power-mode controller.
`ifndef PM_DEFINES_SVH
`define PM_DEFINES_SVH
// =============================================================
// Sizing constants.
`define PM_MAX_CELLS      12
`define PM_MAX_DEVICES    14
`define PM_MAX_SYS_CELLS  168
`define PM_ADC_BITS       14
`define PM_ADDR_BITS      4
`define PM_CELL_BITS      4
// =============================================================
// Fault filter length in clock cycles.
`define PM_FILT_CYCLES    4'h8
`define PM_FILT_BITS      4
// Conversion busy time of the stand-in converter sequencer.
`define PM_CONV_CYCLES    8'h10
`define PM_CONV_BITS      8
// Rails left on in Shutdown: core, sleep regulators, input buffers.
`define PM_RAILS_OFF      8'h07
`endif

//--- pm_pkg.sv
// Types shared by the power-mode controller and its helpers.
package pm_pkg;
  // =============================================================
  // Main power modes.
  typedef enum logic [1:0] {
    mode_normal,
    mode_sleep,
    mode_shutdown
  } power_mode_type;
  // Operating states inside the controller.
  typedef enum logic [2:0] {
    st_shutdown,
    st_standby,
    st_active,
    st_sleep
  } op_state_type;
  // Operations the host may start.
  typedef enum logic [1:0] {
    op_scan_voltages,
    op_scan_all,
    op_measure_one,
    op_open_wire
  } op_kind_type;
  // Balancing modes.
  typedef enum logic [1:0] {
    bal_manual,
    bal_timed,
    bal_auto,
    bal_off
  } bal_mode_type;
  // A command from the host as decoded by the link.
  typedef struct packed {
    logic        start;
    op_kind_type kind;
    logic [3:0]  param;
    logic        sleep;
  } host_cmd_type;
  // Live fault inputs.
  typedef struct packed {
    logic over_v;
    logic under_v;
    logic regulator;
    logic oscillator;
    logic open_input;
    logic comm;
  } fault_set_type;
  // Power enables toward the analog sections.
  typedef struct packed {
    logic main_bias;
    logic main_osc;
    logic low_osc;
    logic comm_in;
    logic regs_kept;
    logic core;
    logic sleep_regs;
    logic in_buffers;
  } power_rail_type;
endpackage : pm_pkg

//--- fault_filter.sv
// Fault debounce filter: a fault must stand steadily before it is flagged.
`timescale 1ns/1ns
`include "pm_defines.svh"
module fault_filter #(
  parameter int WIDTH = 6
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] raw,
  output logic      [WIDTH-1:0] filtered
);
  // =============================================================
  // State.
  typedef struct packed {
    logic [WIDTH-1:0][`PM_FILT_BITS-1:0] cnt;
    logic [WIDTH-1:0]                    flag;
  } filt_state_type;
  filt_state_type state;       // Registered state.
  filt_state_type next_state;  // Next value.

  // Each bit changes its flag only after the raw level held long enough.
  always_comb begin
    next_state = state;
    for (int i = 0; i < WIDTH; i++) begin
      if (raw[i] == state.flag[i]) begin
        next_state.cnt[i] = '0;
      end else if (state.cnt[i] == `PM_FILT_CYCLES - 4'h1) begin
        next_state.flag[i] = raw[i];
        next_state.cnt[i]  = '0;
      end else begin
        next_state.cnt[i] = state.cnt[i] + 4'h1;
      end
    end
  end

  // Registers the state.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign filtered = state.flag;
endmodule : fault_filter

//--- chain_addr.sv
// Chain address check: decides whether a frame is for this chain member.
`timescale 1ns/1ns
`include "pm_defines.svh"
module chain_addr (
  input  wire logic                     clk,
  input  wire logic                     rst_n,
  input  wire logic [`PM_ADDR_BITS-1:0] own_addr,
  input  wire logic [`PM_ADDR_BITS-1:0] frame_addr,
  input  wire logic                     frame_bcast,
  input  wire logic                     frame_valid,
  output logic                          for_me
);
  // =============================================================
  // Valid addresses run 1 to 14; zero and fifteen are never ours.
  function automatic logic addr_ok(input logic [`PM_ADDR_BITS-1:0] a);
    addr_ok = (a != 4'h0) && (a <= 4'(`PM_MAX_DEVICES));
  endfunction : addr_ok

  typedef struct packed {
    logic hit;
  } addr_state_type;
  addr_state_type state;       // Registered match.
  addr_state_type next_state;  // Next value.

  // A broadcast reaches every member; otherwise the addresses must match.
  always_comb begin
    next_state     = state;
    next_state.hit = frame_valid && addr_ok(own_addr)
                     && (frame_bcast || (frame_addr == own_addr));
  end

  // Registers the match.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign for_me = state.hit;
endmodule : chain_addr

//--- power_mode_ctrl.sv
// Power-mode and operating-state controller of a stackable cell monitor.
`timescale 1ns/1ns
`include "pm_defines.svh"
module power_mode_ctrl #(
  parameter int CELLS    = `PM_MAX_CELLS,
  parameter int ADC_BITS = `PM_ADC_BITS
) (
  // Clock and reset.
  input  wire logic                     clk,
  input  wire logic                     rst_n,
  input  wire logic                     enable,
  // Host command from the link.
  input  wire pm_pkg::host_cmd_type     cmd,
  input  wire logic                     cmd_valid,
  // Sleep and wake causes.
  input  wire logic                     wdog_timeout,
  input  wire logic                     comm_activity,
  input  wire logic                     slow_tick,
  // Chain addressing.
  input  wire logic [`PM_ADDR_BITS-1:0] own_addr,
  input  wire logic [`PM_ADDR_BITS-1:0] frame_addr,
  input  wire logic                     frame_bcast,
  // Converter answer.
  input  wire logic                     adc_done,
  input  wire logic [ADC_BITS-1:0]      adc_data,
  // Balancing set-up.
  input  wire pm_pkg::bal_mode_type     bal_mode_sel,
  input  wire logic [CELLS-1:0]         bal_cells,
  input  wire logic                     bal_target_met,
  // Raw faults and reply request.
  input  wire pm_pkg::fault_set_type    fault_raw,
  input  wire logic                     comm_fault_reply_req,
  // All outputs below are flops.
  // Mode, state and rails.
  output pm_pkg::power_mode_type        power_mode,
  output pm_pkg::op_state_type          op_state,
  output pm_pkg::power_rail_type        rails,
  // Converter request and result.
  output logic                          adc_start,
  output pm_pkg::op_kind_type           adc_kind,
  output logic [3:0]                    adc_param,
  output logic [ADC_BITS-1:0]           result,
  output logic                          result_valid,
  // Balancing and fault reports.
  output logic [CELLS-1:0]              bal_drive,
  output pm_pkg::bal_mode_type          bal_mode,
  output pm_pkg::fault_set_type         fault_status,
  output logic                          fault_reply,
  output logic                          fault_unprompted
);
  // =============================================================
  // Whole controller state in one record.
  typedef struct packed {
    pm_pkg::op_state_type   st;            // Operating state.
    pm_pkg::power_mode_type mode;          // Reported main mode.
    pm_pkg::power_rail_type rails;         // Power enables.
    logic                   adc_start;     // Start pulse to converter.
    pm_pkg::op_kind_type    kind;          // Running operation.
    logic [3:0]             param;         // Chosen parameter.
    logic [ADC_BITS-1:0]    result;        // Last result, raw.
    logic                   result_valid;  // One-cycle result strobe.
    logic [CELLS-1:0]       bal_sel;       // Cells picked for balancing.
    logic [CELLS-1:0]       bal_drive;     // Gate drive enables.
    pm_pkg::bal_mode_type   bal_mode;      // Balancing mode in force.
    logic                   bal_run;       // Balancing running.
    pm_pkg::fault_set_type  fault;         // Filtered faults as seen.
    logic                   reply;         // Fault reply strobe.
    logic                   unprompted;    // Unprompted fault strobe.
    logic [`PM_CONV_BITS-1:0] busy;        // Guard timer while active.
  } ctrl_state_type;

  // The copy is registered whole.
  ctrl_state_type state;       // Registered state.
  ctrl_state_type next_state;  // Next value.
  // Helper outputs.
  logic           for_me;      // Current command is addressed here.
  logic [5:0]     fault_filt;  // Debounced fault flags.
  logic           cmd_d;       // Command delayed to meet the address match.
  pm_pkg::host_cmd_type cmd_q; // Command held for one cycle.

  // =============================================================
  // Helpers.
  // The match is registered, so a
  // command acts one edge late.
  chain_addr u_addr (
    .clk         (clk),
    .rst_n       (rst_n),
    .own_addr    (own_addr),
    .frame_addr  (frame_addr),
    .frame_bcast (frame_bcast),
    .frame_valid (cmd_valid),
    .for_me      (for_me)
  );

  // One debounce counter per fault.
  // Results never pass through it.
  fault_filter #(
    .WIDTH (6)
  ) u_filt (
    .clk      (clk),
    .rst_n    (rst_n),
    .raw      (fault_raw),
    .filtered (fault_filt)
  );

  // Holds the command for the cycle the address check takes.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cmd_d <= 1'b0;
      cmd_q <= '0;
    end else begin
      // Both move as one frame.
      cmd_d <= cmd_valid;
      cmd_q <= cmd;
    end
  end

  // Power rails for a given state; every state keeps the core.
  function automatic pm_pkg::power_rail_type rails_for(input pm_pkg::op_state_type s);
    pm_pkg::power_rail_type r;
    r = '0;
    // The always-on set.
    r.core       = 1'b1;
    r.sleep_regs = 1'b1;
    r.in_buffers = 1'b1;
    // The rest depends on the state.
    unique case (s)
      pm_pkg::st_shutdown: begin
        // Always-on set only; the core holds the set-up.
      end

      // Link inputs, slow clock, registers.
      pm_pkg::st_sleep: begin
        r.comm_in   = 1'b1;
        r.low_osc   = 1'b1;
        r.regs_kept = 1'b1;
      end

      // Normal mode powers everything.
      pm_pkg::st_standby, pm_pkg::st_active: begin
        r = '1;
      end
    endcase
    return r;
  endfunction : rails_for

  // Main mode that a state belongs to.
  function automatic pm_pkg::power_mode_type mode_for(input pm_pkg::op_state_type s);
    unique case (s)
      pm_pkg::st_shutdown: mode_for = pm_pkg::mode_shutdown;
      pm_pkg::st_sleep:    mode_for = pm_pkg::mode_sleep;
      // Standby and active are Normal.
      default:             mode_for = pm_pkg::mode_normal;
    endcase
  endfunction : mode_for

  // =============================================================
  // Next-state logic.
  always_comb begin
    logic go;
    go = cmd_d && for_me;
    // Pulses drop unless raised below.
    next_state              = state;
    // Strobes last a single cycle.
    next_state.adc_start    = 1'b0;
    next_state.result_valid = 1'b0;
    next_state.reply        = 1'b0;
    next_state.unprompted   = 1'b0;

    // Fault flags follow the debounced paths and stay readable.
    next_state.fault = pm_pkg::fault_set_type'(fault_filt);
    // A newly filtered comm fault is sent without a request.
    if (fault_filt[0] && !state.fault.comm) begin
      next_state.unprompted = 1'b1;
    end
    // A pending comm fault also answers an addressed command while a reply is requested.
    if (go && state.fault.comm && comm_fault_reply_req) begin
      next_state.reply = 1'b1;
    end

    unique case (state.st)
      pm_pkg::st_shutdown: begin
        // Configuration is left in place; wake goes straight to standby.
        if (enable) begin
          // Registers kept their contents.
          next_state.st = pm_pkg::st_standby;
        end
      end

      // Powered, waiting for a command.
      pm_pkg::st_standby: begin
        // Sleep wins over a start.
        if (wdog_timeout || (go && cmd_q.sleep)) begin
          next_state.st = pm_pkg::st_sleep;
        end else if (go && cmd_q.start) begin
          // Run from the held copy, not the
          // live bus; one start pulse.
          next_state.st        = pm_pkg::st_active;
          next_state.kind      = cmd_q.kind;
          next_state.param     = cmd_q.param;
          next_state.adc_start = 1'b1;
          next_state.busy      = '0;
        end
      end

      // Busy until the converter is done or the watchdog fires.
      pm_pkg::st_active: begin
        // Cycles spent converting.
        next_state.busy = state.busy + 8'h1;
        if (adc_done) begin
          // Result is passed exactly as converted.
          next_state.result       = adc_data;
          next_state.result_valid = 1'b1;
          next_state.st           = pm_pkg::st_standby;
        end else if (wdog_timeout) begin
          // A lost host ends the operation.
          next_state.st = pm_pkg::st_sleep;
        end
      end

      // Asleep until the link stirs.
      pm_pkg::st_sleep: begin
        // Any activity on the link inputs wakes the part.
        if (comm_activity) begin
          // Wake never lands in active.
          next_state.st = pm_pkg::st_standby;
        end
      end

      // A stray code falls to Shutdown.
      default: begin
        next_state.st = pm_pkg::st_shutdown;
      end
    endcase

    // Balancing: manual drives the selection, timed and auto run until stopped.
    if (go && cmd_q.start) begin
      next_state.bal_mode = bal_mode_sel;
      next_state.bal_sel  = bal_cells;
      next_state.bal_run  = (bal_mode_sel != pm_pkg::bal_off);
    end

    // Timed and auto each have their own stop event; manual has none.
    unique case (state.bal_mode)
      pm_pkg::bal_timed: begin
        // The slow tick ends the window.
        if (slow_tick) begin
          next_state.bal_run = 1'b0;
        end
      end
      pm_pkg::bal_auto: begin
        // The charge target was met.
        if (bal_target_met) begin
          next_state.bal_run = 1'b0;
        end
      end
      pm_pkg::bal_manual, pm_pkg::bal_off: begin
        // Manual runs until the next start.
        next_state.bal_run = next_state.bal_run;
      end
    endcase

    // Gate drive current sources are off outside Normal mode.
    if (next_state.st == pm_pkg::st_standby || next_state.st == pm_pkg::st_active) begin
      next_state.bal_drive = next_state.bal_run ? next_state.bal_sel : '0;
    end else begin
      next_state.bal_drive = '0;
    end

    // Enable low beats every other transition, in the same cycle.
    if (!enable) begin
      // No start pulse or gate drive leaks into Shutdown.
      next_state.st        = pm_pkg::st_shutdown;
      next_state.adc_start = 1'b0;
      next_state.bal_drive = '0;
    end

    // Mode and rails follow the new state.
    next_state.mode  = mode_for(next_state.st);
    next_state.rails = rails_for(next_state.st);
  end

  // =============================================================
  // State register; the part starts in Shutdown until enable is seen.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      // Clear all, then the Shutdown values.
      state          <= '0;
      state.st       <= pm_pkg::st_shutdown;
      state.mode     <= pm_pkg::mode_shutdown;
      state.bal_mode <= pm_pkg::bal_off;
      state.rails    <= `PM_RAILS_OFF;
    end else begin
      // The record moves as one.
      state <= next_state;
    end
  end

  // =============================================================
  // Outputs, all straight from the state register.
  // Mode and state.
  assign power_mode       = state.mode;
  assign op_state         = state.st;
  assign rails            = state.rails;

  // Converter side.
  assign adc_start        = state.adc_start;
  assign adc_kind         = state.kind;
  assign adc_param        = state.param;
  assign result           = state.result;
  assign result_valid     = state.result_valid;

  // Balancing.
  assign bal_drive        = state.bal_drive;
  assign bal_mode         = state.bal_mode;

  // Fault reports.
  assign fault_status     = state.fault;
  assign fault_reply      = state.reply;
  assign fault_unprompted = state.unprompted;
endmodule : power_mode_ctrl

//--- pm_checker_assertions.sv
// Port-level property checker for the power-mode controller.
`timescale 1ns/1ns
module pm_checker #(
  parameter int ADC_BITS = 14
) (
  input wire logic                   clk,
  input wire logic                   rst_n,
  input wire logic                   enable,
  input wire logic                   wdog_timeout,
  input wire logic                   comm_activity,
  input wire logic                   adc_done,
  input wire logic [ADC_BITS-1:0]    adc_data,
  input wire pm_pkg::fault_set_type  fault_raw,
  input wire pm_pkg::power_mode_type power_mode,
  input wire pm_pkg::op_state_type   op_state,
  input wire pm_pkg::power_rail_type rails,
  input wire logic [ADC_BITS-1:0]    result,
  input wire logic                   result_valid,
  input wire pm_pkg::fault_set_type  fault_status
);
  // =============================================================
  // Properties, all in the one clock domain.
  default clocking dc @(posedge clk); endclocking
  default disable iff (!rst_n);
  property p_en_low;
    !enable |=> op_state == pm_pkg::st_shutdown && power_mode == pm_pkg::mode_shutdown;
  endproperty
  a_en_low: assert property (p_en_low)
    else $error("enable low did not force shutdown");
  property p_off_rails;
    op_state == pm_pkg::st_shutdown |-> power_mode == pm_pkg::mode_shutdown && rails == 8'h07;
  endproperty
  a_off_rails: assert property (p_off_rails)
    else $error("shutdown rails wrong");
  property p_sleep_rails;
    op_state == pm_pkg::st_sleep |-> power_mode == pm_pkg::mode_sleep && rails.low_osc
      && rails.comm_in && rails.regs_kept && !rails.main_bias;
  endproperty
  a_sleep_rails: assert property (p_sleep_rails)
    else $error("sleep rails wrong");
  property p_standby;
    op_state == pm_pkg::st_standby |-> power_mode == pm_pkg::mode_normal && rails == 8'hFF;
  endproperty
  a_standby: assert property (p_standby)
    else $error("standby not fully powered");
  property p_wake;
    op_state == pm_pkg::st_sleep && comm_activity && enable |=> op_state == pm_pkg::st_standby;
  endproperty
  a_wake: assert property (p_wake)
    else $error("no wake on activity");
  property p_done;
    op_state == pm_pkg::st_active && adc_done && enable |=> result_valid
      && result == $past(adc_data) && op_state == pm_pkg::st_standby;
  endproperty
  a_done: assert property (p_done)
    else $error("conversion end handled wrongly");
  property p_wdog;
    op_state == pm_pkg::st_standby && wdog_timeout && enable && !comm_activity
      |-> ##[1:3] op_state == pm_pkg::st_sleep;
  endproperty
  a_wdog: assert property (p_wdog)
    else $error("watchdog did not put device to sleep");
  property p_filter;
    $rose(fault_status.over_v) |-> $past(fault_raw.over_v, 8) && $past(fault_raw.over_v, 4);
  endproperty
  a_filter: assert property (p_filter)
    else $error("fault flagged before filtering");
  c_sleep: cover property (op_state == pm_pkg::st_sleep);
  c_done: cover property (result_valid);
  c_fault: cover property ($rose(fault_status.over_v));
endmodule : pm_checker
bind power_mode_ctrl pm_checker #(.ADC_BITS(ADC_BITS)) u_chk (.clk(clk), .rst_n(rst_n),
  .enable(enable), .wdog_timeout(wdog_timeout), .comm_activity(comm_activity),
  .adc_done(adc_done), .adc_data(adc_data), .fault_raw(fault_raw), .power_mode(power_mode),
  .op_state(op_state), .rails(rails), .result(result), .result_valid(result_valid),
  .fault_status(fault_status));

//--- adc_partner.sv
// Stand-in converter that answers each start request after a set delay.
`timescale 1ns/1ns
module adc_partner (
  input wire logic                clk,
  input wire logic                rst_n,
  input wire logic                adc_start,
  input wire pm_pkg::op_kind_type adc_kind,
  input wire logic [3:0]          adc_param,
  input wire logic [7:0]          delay,
  output logic                    adc_done,
  output logic [13:0]             adc_data
);
  logic [7:0]  count; // Cycles left in the conversion.
  logic        busy;  // A conversion is running.
  logic [13:0] held;  // Result built from the request so the bench can predict it.
  // =============================================================
  // Outside the done pulse the data toggles, so a stale sample is never a match.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      busy <= 1'b0;
      count <= 8'h00;
      held <= 14'h0000;
      adc_done <= 1'b0;
      adc_data <= 14'h0000;
    end else begin
      adc_done <= 1'b0;
      adc_data <= ~adc_data;
      if (adc_start) begin
        busy <= 1'b1;
        count <= delay;
        held <= {adc_kind, adc_param, 8'hC3};
      end else if (busy && count == 8'h00) begin
        busy <= 1'b0;
        adc_done <= 1'b1;
        adc_data <= held;
      end else if (busy) begin
        count <= count - 8'h01;
      end
    end
  end
endmodule : adc_partner

//--- testbench.sv
// Self-checking bench for the power-mode controller.
`timescale 1ns/1ns
module testbench;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic enable = 1'b1;
  pm_pkg::host_cmd_type cmd = '0;
  logic cmd_valid = 1'b0;
  logic wdog_timeout = 1'b0;
  logic comm_activity = 1'b0;
  logic slow_tick = 1'b0;
  logic comm_fault_reply_req = 1'b0;
  logic [3:0] frame_addr = 4'h0;
  logic adc_done;
  logic [13:0] adc_data;
  pm_pkg::bal_mode_type bal_mode_sel = pm_pkg::bal_off;
  logic [11:0] bal_cells = 12'h000;
  pm_pkg::fault_set_type fault_raw = '0;
  pm_pkg::power_mode_type power_mode;
  pm_pkg::op_state_type op_state;
  pm_pkg::power_rail_type rails;
  logic adc_start, result_valid, fault_reply, fault_unprompted;
  pm_pkg::op_kind_type adc_kind;
  pm_pkg::bal_mode_type bal_mode;
  pm_pkg::fault_set_type fault_status;
  logic [3:0] adc_param;
  logic [13:0] result;
  logic [11:0] bal_drive;
  logic [7:0] delay = 8'h00;
  int fails = 0;
  int tests_run = 0;
  int cycles = 0;
  // The clock, 8 ns period.
  always #4 clk = ~clk;
  power_mode_ctrl dut (.clk(clk), .rst_n(rst_n), .enable(enable), .cmd(cmd),
    .cmd_valid(cmd_valid), .wdog_timeout(wdog_timeout), .comm_activity(comm_activity),
    .slow_tick(slow_tick), .own_addr(4'h5), .frame_addr(frame_addr), .frame_bcast(1'b0),
    .adc_done(adc_done), .adc_data(adc_data), .bal_mode_sel(bal_mode_sel),
    .bal_cells(bal_cells), .bal_target_met(1'b0), .fault_raw(fault_raw),
    .comm_fault_reply_req(comm_fault_reply_req), .power_mode(power_mode), .op_state(op_state),
    .rails(rails), .adc_start(adc_start), .adc_kind(adc_kind), .adc_param(adc_param),
    .result(result), .result_valid(result_valid), .bal_drive(bal_drive),
    .bal_mode(bal_mode), .fault_status(fault_status), .fault_reply(fault_reply),
    .fault_unprompted(fault_unprompted));
  adc_partner host (.clk(clk), .rst_n(rst_n), .adc_start(adc_start), .adc_kind(adc_kind),
    .adc_param(adc_param), .delay(delay), .adc_done(adc_done), .adc_data(adc_data));
  // =============================================================
  // Helpers: inputs always change 1 ns after the rising edge.
  task automatic tick(int n = 1);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick
  task automatic chk(logic [31:0] got, logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // One command frame; it is acted on one edge after it is taken.
  task automatic send(logic st, logic sl, logic [1:0] k, logic [3:0] a);
    cmd = '{start: st, kind: pm_pkg::op_kind_type'(k), param: {2'b10, k}, sleep: sl};
    frame_addr = a;
    cmd_valid = 1'b1;
    tick();
    cmd_valid = 1'b0;
    tick();
  endtask : send
  task automatic wait_valid();
    for (int i = 0; i < 300 && result_valid !== 1'b1; i++) tick();
    chk(result_valid, 1'b1);
  endtask : wait_valid
  // =============================================================
  // Scenarios.
  task automatic t_ops(); // Every operation kind and balance mode, prompt and slow.
    for (int k = 0; k < 4; k++) begin
      delay = 8'(k * 7);
      bal_mode_sel = pm_pkg::bal_mode_type'(k);
      bal_cells = 12'h001 << k;
      send(1'b1, 1'b0, 2'(k), 4'h5);
      chk(op_state, pm_pkg::st_active);
      chk(adc_start, 1'b1);
      chk(adc_kind, k);
      chk(adc_param, {2'b10, 2'(k)});
      chk(bal_drive, k == 3 ? 12'h000 : 12'h001 << k);
      wait_valid();
      chk(result, {2'(k), 2'b10, 2'(k), 8'hC3});
      chk(op_state, pm_pkg::st_standby);
      chk(bal_mode, k);
    end
  endtask : t_ops
  task automatic t_busy(); // A second start while active, and foreign addresses.
    delay = 8'd20;
    send(1'b1, 1'b0, 2'd1, 4'h5);
    send(1'b1, 1'b0, 2'd2, 4'h5);
    wait_valid();
    chk(result, {2'd1, 4'b1001, 8'hC3});
    tick(5);
    chk(op_state, pm_pkg::st_standby);
    send(1'b1, 1'b0, 2'd0, 4'h0);
    send(1'b1, 1'b0, 2'd0, 4'hF);
    tick(2);
    chk(op_state, pm_pkg::st_standby);
  endtask : t_busy
  task automatic wake(); // Activity on the link brings the device back to standby.
    comm_activity = 1'b1;
    tick();
    comm_activity = 1'b0;
    chk(op_state, pm_pkg::st_standby);
  endtask : wake
  task automatic t_sleep(); // Sleep by command, then by watchdog.
    send(1'b0, 1'b1, 2'd0, 4'h5);
    tick();
    chk(op_state, pm_pkg::st_sleep);
    chk(power_mode, pm_pkg::mode_sleep);
    send(1'b1, 1'b0, 2'd0, 4'h5);
    tick(2);
    chk(op_state, pm_pkg::st_sleep);
    wake();
    wdog_timeout = 1'b1;
    tick();
    wdog_timeout = 1'b0;
    for (int i = 0; i < 4 && op_state !== pm_pkg::st_sleep; i++) tick();
    chk(op_state, pm_pkg::st_sleep);
    wake();
  endtask : t_sleep
  task automatic t_enable(); // Enable low in mid-operation, then back.
    delay = 8'd30;
    bal_mode_sel = pm_pkg::bal_timed;
    send(1'b1, 1'b0, 2'd3, 4'h5);
    tick(2);
    enable = 1'b0;
    tick();
    chk(op_state, pm_pkg::st_shutdown);
    chk(rails, 8'h07);
    chk(bal_drive, 12'h000);
    enable = 1'b1;
    tick(2);
    chk(op_state, pm_pkg::st_standby);
    chk(bal_mode, pm_pkg::bal_timed);
    chk(bal_drive, 12'h008);
    slow_tick = 1'b1;
    tick();
    slow_tick = 1'b0;
    chk(bal_drive, 12'h000);
    tick(40);
  endtask : t_enable
  task automatic t_faults(); // A glitch is filtered out; a steady fault is flagged.
    int pulses;
    pulses = 0;
    fault_raw = 6'h10;
    tick(3);
    fault_raw = 6'h00;
    tick(14);
    chk(fault_status, 6'h00);
    fault_raw = 6'h2F;
    for (int i = 0; i < 14; i++) begin
      pulses += (fault_unprompted === 1'b1);
      tick();
    end
    chk(fault_status, 6'h2F);
    chk(pulses, 1);
    comm_fault_reply_req = 1'b1;
    send(1'b0, 1'b0, 2'd0, 4'h5);
    chk(fault_reply, 1'b1);
    comm_fault_reply_req = 1'b0;
    fault_raw = 6'h00;
    tick(14);
    chk(fault_status, 6'h00);
  endtask : t_faults
  // =============================================================
  // Verdict and hang guard.
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : wrap_up
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      wrap_up();
    end
  end
  initial begin
    tick(19);
    chk(op_state, pm_pkg::st_shutdown);
    chk(bal_mode, pm_pkg::bal_off);
    tick();
    rst_n = 1'b1;
    tick(3);
    chk(op_state, pm_pkg::st_standby);
    t_ops();
    t_busy();
    t_sleep();
    t_enable();
    t_faults();
    wrap_up();
  end
endmodule : testbench
